// >>> hdl/lcg_pkg.sv
package lcg_pkg;
   // register byte offsets on the bus
   localparam logic [11:0] DATA4_SEL_OFS   = 12'h000;
   localparam logic [11:0] GATE1_EN_OFS    = 12'h004;
   localparam logic [11:0] GATE1_POL_OFS   = 12'h008;
   // field layout of the data input 4 source register
   localparam int          SRC_CODE_W      = 5;
   localparam int          SRC_COUNT       = 32;
   // field layout of the polarity register
   localparam int          GATE1_INV_BIT   = 0;
   // gate 1 enable bit positions, true bit of each pair sits one above
   localparam int          G1_IN1_INV_BIT  = 0;
   localparam int          G1_IN1_TRUE_BIT = 1;
   localparam int          G1_IN4_TRUE_BIT = 7;
   // register width, reset values and transfer codes of the bus slave
   localparam int          REG_W           = 8;
   localparam logic [31:0] RDATA_RST       = 32'h0000_0000;
   localparam logic        HREADY_RST      = 1'b1;
   localparam logic        HRESP_OKAY      = 1'b0;
   localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
   localparam logic [1:0]  HTRANS_SEQ      = 2'h3;
endpackage : lcg_pkg

// >>> hdl/lcg_gate1_select.sv
`timescale 1ns/10ps
`default_nettype none

// Operation
// - upper three source bits read zero, ignored
// - five-bit code picks data input 4 source
// - select bits not reset, kept through reset
// - enable bit one puts input into gate
// - enable bit zero keeps input out
// - eight enable bits, in4 true down to in1 inverted
// - polarity bit inverts gate 1 term
module lcg_gate1_select #(
   parameter int ADDR_W = 12                           // decoded address bits
) (
   input  wire logic        ref_clk_i,                 // 10 MHz clock
   input  wire logic        rst_i,                     // sync reset, active high
   input  wire logic        hsel_i,                    // slave select
   input  wire logic [31:0] haddr_i,                   // byte address
   input  wire logic [1:0]  htrans_i,                  // transfer type
   input  wire logic        hwrite_i,                  // write when high
   input  wire logic [2:0]  hsize_i,                   // transfer size
   input  wire logic        hready_i,                  // bus ready
   input  wire logic [31:0] hwdata_i,                  // write data
   output logic      [31:0] hrdata_o,                  // read data
   output logic             hreadyout_o,               // slave ready
   output logic             hresp_o,                   // response, always okay
   input  wire logic [31:0] data4_sources_i,           // candidate sources for input 4
   input  wire logic        data1_i,                   // data input 1 true level
   input  wire logic        data2_i,                   // data input 2 true level
   input  wire logic        data3_i,                   // data input 3 true level
   output logic             data4_true_o,              // selected input 4, true
   output logic             data4_inv_o,               // selected input 4, inverted
   output logic             first_gate_term_o          // gate 1 term after polarity
);

   // configuration registers, deliberately without reset
   logic [lcg_pkg::SRC_CODE_W-1:0] data4_source_code_reg;   // input 4 source code
   logic [lcg_pkg::REG_W-1:0]      gate1_input_enable_reg;  // gate 1 enables
   logic                           first_gate_invert_reg;   // gate 1 polarity
   // bus data phase state
   logic              wr_pend_reg;                     // write data phase pending
   logic [ADDR_W-1:0] wr_addr_reg;                     // address of pending write
   // combinational helpers
   logic              rd_take;                         // read address phase taken
   logic              wr_take;                         // write address phase taken
   logic [31:0]       rd_next;                         // next read data
   logic              data4_sel;                       // chosen input 4 level
   logic [7:0]        in_vec;                          // true and inverted inputs
   logic              term_raw;                        // gate 1 before polarity

   // register image of an address, unmapped reads zero
   function automatic logic [31:0] read_image(input logic [ADDR_W-1:0] a,
                                              input logic [4:0] code,
                                              input logic [7:0] en,
                                              input logic inv);
      logic [31:0] r;
      r = 32'h0000_0000;
      if (a == lcg_pkg::DATA4_SEL_OFS[ADDR_W-1:0]) begin
         r[lcg_pkg::SRC_CODE_W-1:0] = code;            // bits above stay zero
      end else if (a == lcg_pkg::GATE1_EN_OFS[ADDR_W-1:0]) begin
         r[lcg_pkg::REG_W-1:0] = en;
      end else if (a == lcg_pkg::GATE1_POL_OFS[ADDR_W-1:0]) begin
         r[lcg_pkg::GATE1_INV_BIT] = inv;
      end
      return r;
   endfunction : read_image

   // address phase qualification, transfers of any size are taken
   assign rd_take = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
   assign wr_take = hsel_i && hready_i && htrans_i[1] && hwrite_i;

   // read data, forwarding a write that completes in this same cycle
   always_comb begin
      rd_next = read_image(haddr_i[ADDR_W-1:0], data4_source_code_reg,
                           gate1_input_enable_reg, first_gate_invert_reg);
      if (wr_pend_reg && wr_addr_reg == haddr_i[ADDR_W-1:0]) begin
         rd_next = read_image(wr_addr_reg, hwdata_i[4:0], hwdata_i[7:0],
                              hwdata_i[lcg_pkg::GATE1_INV_BIT]);
      end
   end

   // bus slave state; zero wait states keeps hreadyout high
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= '0;
         hrdata_o    <= lcg_pkg::RDATA_RST;
         hreadyout_o <= lcg_pkg::HREADY_RST;
         hresp_o     <= lcg_pkg::HRESP_OKAY;
      end else begin
         wr_pend_reg <= wr_take;
         hreadyout_o <= lcg_pkg::HREADY_RST;
         hresp_o     <= lcg_pkg::HRESP_OKAY;
         if (wr_take) begin
            wr_addr_reg <= haddr_i[ADDR_W-1:0];
         end
         // read data stands for the data phase only
         if (rd_take) begin
            hrdata_o <= rd_next;
         end else begin
            hrdata_o <= lcg_pkg::RDATA_RST;
         end
      end
   end

   // no reset term
   // these stay unknown from power-up and bus reset leaves them alone
   always_ff @(posedge ref_clk_i) begin
      if (wr_pend_reg) begin
         // upper bits dropped
         // only the five code bits are stored, writes above are lost
         if (wr_addr_reg == lcg_pkg::DATA4_SEL_OFS[ADDR_W-1:0]) begin
            data4_source_code_reg <= hwdata_i[lcg_pkg::SRC_CODE_W-1:0];
         end else if (wr_addr_reg == lcg_pkg::GATE1_EN_OFS[ADDR_W-1:0]) begin
            gate1_input_enable_reg <= hwdata_i[lcg_pkg::REG_W-1:0];
         end else if (wr_addr_reg == lcg_pkg::GATE1_POL_OFS[ADDR_W-1:0]) begin
            first_gate_invert_reg <= hwdata_i[lcg_pkg::GATE1_INV_BIT];
         end
      end
   end

   assign data4_sel = data4_sources_i[data4_source_code_reg];

   // true and complement pairs
   // pair k holds input k+1; true bit above inverted bit
   assign in_vec = {data4_sel, ~data4_sel, data3_i, ~data3_i,
                    data2_i, ~data2_i, data1_i, ~data1_i};

   // disabled inputs masked
   // an empty enable set gives a zero term, before polarity
   assign term_raw = |(gate1_input_enable_reg & in_vec);

   // registered outputs toward the logic function
   always_ff @(posedge ref_clk_i) begin
      data4_true_o <= data4_sel;
      data4_inv_o  <= ~data4_sel;
      first_gate_term_o <= term_raw ^ first_gate_invert_reg;
   end

   // assertions
   logic past_ok;                                      // one cycle out of reset
   always_ff @(posedge ref_clk_i) begin
      past_ok <= !rst_i;
   end

   // which configuration registers were written since power-up;
   // before that they hold unknowns, so checks that read them would
   // misfire on the undefined contents rather than on a real fault
   logic [2:0] cfg_seen_reg = 3'b000;                  // bit0 source, bit1 enable, bit2 polarity
   always_ff @(posedge ref_clk_i) begin
      if (wr_pend_reg) begin
         if (wr_addr_reg == lcg_pkg::DATA4_SEL_OFS[ADDR_W-1:0]) begin
            cfg_seen_reg[0] <= 1'b1;
         end else if (wr_addr_reg == lcg_pkg::GATE1_EN_OFS[ADDR_W-1:0]) begin
            cfg_seen_reg[1] <= 1'b1;
         end else if (wr_addr_reg == lcg_pkg::GATE1_POL_OFS[ADDR_W-1:0]) begin
            cfg_seen_reg[2] <= 1'b1;
         end
      end
   end

   src_read_zero_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      rd_take && haddr_i[ADDR_W-1:0] == lcg_pkg::DATA4_SEL_OFS[ADDR_W-1:0]
      |=> hrdata_o[31:5] == 27'h0000000)
      else $error("source register upper bits not zero");
   src_write_code_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      wr_pend_reg && wr_addr_reg == lcg_pkg::DATA4_SEL_OFS[ADDR_W-1:0]
      |=> data4_source_code_reg == $past(hwdata_i[4:0]))
      else $error("source code not stored");
   src_route_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      past_ok && $past(cfg_seen_reg[0])
      |-> data4_true_o == $past(data4_sources_i[data4_source_code_reg])
      && data4_inv_o == !data4_true_o)
      else $error("input 4 not routed from chosen source");
   keep_reset_a: assert property (@(posedge ref_clk_i)
      rst_i && !wr_pend_reg && cfg_seen_reg[1:0] == 2'b11
      |=> $stable(gate1_input_enable_reg) && $stable(data4_source_code_reg))
      else $error("select bits changed by reset");
   gate_include_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      past_ok && &cfg_seen_reg && |(gate1_input_enable_reg & in_vec)
      |=> first_gate_term_o == !$past(first_gate_invert_reg))
      else $error("enabled active input not gated in");
   gate_exclude_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      past_ok && &cfg_seen_reg && gate1_input_enable_reg == 8'h00
      |=> first_gate_term_o == $past(first_gate_invert_reg))
      else $error("disabled inputs reached gate 1");
   enable_layout_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      wr_pend_reg && wr_addr_reg == lcg_pkg::GATE1_EN_OFS[ADDR_W-1:0]
      |=> gate1_input_enable_reg == $past(hwdata_i[7:0]))
      else $error("gate 1 enable register not written");
   polarity_flip_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      past_ok && &cfg_seen_reg && $past(&cfg_seen_reg)
      && $changed(first_gate_invert_reg) && $stable(term_raw)
      |=> $changed(first_gate_term_o))
      else $error("polarity bit did not flip gate 1 term");
   pair_form_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      cfg_seen_reg[0]
      |-> in_vec[lcg_pkg::G1_IN1_TRUE_BIT] != in_vec[lcg_pkg::G1_IN1_INV_BIT]
      && in_vec[lcg_pkg::G1_IN4_TRUE_BIT] == data4_sel)
      else $error("true and inverted forms not complementary");
   bus_okay_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      past_ok |-> hreadyout_o && !hresp_o)
      else $error("slave stalled or errored");

   // main scenarios worth seeing at least once
   reset_kept_c: cover property (@(posedge ref_clk_i)
      rst_i && cfg_seen_reg[1:0] == 2'b11);
   source_high_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
      data4_true_o && !data4_inv_o);

   wr_then_rd_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
      wr_pend_reg ##1 rd_take);
   gate_on_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
      first_gate_term_o && !first_gate_invert_reg);
   gate_inverted_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
      first_gate_invert_reg ##1 !first_gate_term_o);

endmodule : lcg_gate1_select

`default_nettype wire

// >>> test/lcg_gate1_select_tb.sv
`timescale 1ns/10ps
`default_nettype none
module lcg_gate1_select_tb;
   logic        ref_clk_i    = 1'b0;   // 10 MHz bench clock
   logic        rst_i        = 1'b1;   // sync reset, held at start
   logic        hsel         = 1'b0;   // slave select
   logic [31:0] haddr        = 32'h0;  // byte address
   logic [1:0]  htrans       = 2'h0;   // idle at start
   logic        hwrite       = 1'b0;   // write flag
   logic [31:0] hwdata       = 32'h0;  // write data
   logic [31:0] srcs         = 32'h0;  // input 4 candidates
   logic [3:0]  din          = 4'h0;   // inputs 1..3 on bits 0..2
   logic [31:0] hrdata;                // read data
   logic        hready;                // slave ready, fed back as bus ready
   logic        hresp;                 // response
   logic        d4t;                   // selected input 4, true
   logic        d4n;                   // selected input 4, inverted
   logic        term;                  // gate 1 term
   logic [31:0] rd;                    // last read word
   logic [3:0]  dv;                    // input vector for gate tests
   int          bad_count    = 0;      // mismatches seen
   int          total_checks = 0;      // comparisons made

   lcg_gate1_select lcg_gate1_select_i (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hready),
      .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .data4_sources_i(srcs), .data1_i(din[0]), .data2_i(din[1]), .data3_i(din[2]),
      .data4_true_o(d4t), .data4_inv_o(d4n), .first_gate_term_o(term));

   // free-running clock, 100 ns period
   always #50 ref_clk_i = ~ref_clk_i;

   // one comparison, four-state exact
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // verdict and end of run
   task automatic give_verdict;
      if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : give_verdict

   // single word transfer; waits on ready, never assumes a latency
   task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge ref_clk_i);
      hsel <= 1'b1; haddr <= {20'h0, a}; hwrite <= w; htrans <= lcg_pkg::HTRANS_NONSEQ;
      @(posedge ref_clk_i);
      while (hready !== 1'b1) @(posedge ref_clk_i);
      htrans <= 2'h0; hwdata <= d;
      @(posedge ref_clk_i);
      while (hready !== 1'b1) @(posedge ref_clk_i);
      r = hrdata;
   endtask : bus

   // drive data inputs, let one sampling edge pass, then settle
   task automatic apply(input logic [3:0] d, input logic [31:0] s);
      @(posedge ref_clk_i);
      din <= d; srcs <= s;
      @(posedge ref_clk_i);
      #1;
   endtask : apply

   initial begin
      repeat (6) @(posedge ref_clk_i);
      #1;
      check({hrdata[31:2], hready, hresp}, 32'h2);
      @(posedge ref_clk_i);
      rst_i <= 1'b0;
      // every source code, upper bits written as ones
      for (int n = 0; n < 32; n++) begin
         bus(lcg_pkg::DATA4_SEL_OFS, 1'b1, 32'hFFFF_FFE0 | n, rd);
         bus(lcg_pkg::DATA4_SEL_OFS, 1'b0, 32'h0, rd);
         check(rd, 32'(n));
         apply(4'h0, 32'h1 << n);
         check({30'h0, d4t, d4n}, 32'h2);
         apply(4'h0, ~(32'h1 << n));
         check({30'h0, d4t, d4n}, 32'h1);
      end
      for (int p = 0; p < 2; p++) begin
         bus(lcg_pkg::GATE1_POL_OFS, 1'b1, 32'(p), rd);
         bus(lcg_pkg::GATE1_EN_OFS, 1'b1, 32'h0, rd);
         apply(4'h5, 32'hFFFF_FFFF);
         check({31'h0, term}, 32'(p));
         for (int k = 0; k < 8; k++) begin
            bus(lcg_pkg::GATE1_EN_OFS, 1'b1, 32'h1 << k, rd);
            for (int v = 0; v < 2; v++) begin
               // selected input differs from all the others
               dv = (v == 1) ? (4'h1 << (k / 2)) : ~(4'h1 << (k / 2));
               apply(dv, {32{dv[3]}});
               check({31'h0, term}, 32'(((k % 2 == 1) ? v : 1 - v) ^ p));
            end
         end
         bus(lcg_pkg::GATE1_EN_OFS, 1'b1, 32'hFF, rd);
         apply(4'h0, 32'h0);
         check({31'h0, term}, 32'(1 ^ p));
      end
      bus(lcg_pkg::GATE1_POL_OFS, 1'b0, 32'h0, rd);
      check(rd, 32'h1);
      bus(lcg_pkg::GATE1_EN_OFS, 1'b1, 32'h5A, rd);
      bus(lcg_pkg::GATE1_EN_OFS, 1'b0, 32'h0, rd);
      check(rd, 32'h5A);
      // unmapped place reads zero, write has no effect
      bus(12'h00C, 1'b1, 32'hFF, rd);
      bus(12'h00C, 1'b0, 32'h0, rd);
      check(rd, 32'h0);
      @(posedge ref_clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      bus(lcg_pkg::GATE1_EN_OFS, 1'b0, 32'h0, rd);
      check(rd, 32'h5A);
      bus(lcg_pkg::DATA4_SEL_OFS, 1'b0, 32'h0, rd);
      check(rd, 32'h1F);
      give_verdict();
   end

   // watchdog, well beyond the roughly 500 cycles the tests need
   initial begin
      #(100 * 20000);
      bad_count++;
      give_verdict();
   end
endmodule : lcg_gate1_select_tb
`default_nettype wire
